/* File: dv/dee_ctrl_properties.sv */
// Port checker for the data array controller.
// Bound into dee_ctrl; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module dee_chk #(
	parameter int WRITE_CYCLES = 4
) (
	input wire logic              clock,
	input wire logic              rst,
	input wire dee_pkg::dee_req_t sfr_req,
	input wire logic [7:0]        sfr_rdata,
	input wire logic              write_done_irq_flag,
	input wire logic              write_active
);
	import dee_pkg::*;
	default clocking @(posedge clock); endclocking
	logic rst_d;
	logic row_arm;
	int   busy_n;
	// Reset drops the write bit, so the edge just after release must not look like a write end
	always_ff @(posedge clock) begin
		rst_d <= rst;
	end
	default disable iff (rst || rst_d);
	// Row erase setting as written by the start command; a row erase runs the erase phase only
	always_ff @(posedge clock) begin
		if (rst) begin
			row_arm <= 1'b0;
		end else if (sfr_req.wr && sfr_req.sel == DEE_SEL_CTL && !write_active) begin
			row_arm <= sfr_req.wdata[DEE_B_ROWER];
		end
	end
	// Counts run length; a counter keeps the length check free of long repetitions
	always_ff @(posedge clock) begin
		if (rst || !write_active)
			busy_n <= 0;
		else
			busy_n <= busy_n + 1;
	end
	sequence s_run;
		write_active [*2];
	endsequence
	sequence s_finish;
		write_done_irq_flag ##1 !write_active;
	endsequence
	a_busy_length: assert property ($fell(write_active)
		|-> busy_n == (row_arm ? WRITE_CYCLES / 2 : WRITE_CYCLES))
		else $error("write length wrong");
	a_busy_run: assert property ($rose(write_active) |-> s_run)
		else $error("write ended early");
	a_done_flag: assert property ($fell(write_active) |-> s_finish)
		else $error("flag missing at write end");
	a_flag_cause: assert property ($rose(write_done_irq_flag) |-> $fell(write_active))
		else $error("flag set without write end");
	a_flag_sticky: assert property (write_done_irq_flag && !(sfr_req.wr && sfr_req.sel == DEE_SEL_IRQ)
		|=> write_done_irq_flag)
		else $error("flag dropped by itself");
	a_start_cause: assert property ($rose(write_active)
		|-> $past(sfr_req.wr && sfr_req.sel == DEE_SEL_CTL && sfr_req.wdata[DEE_B_WR]))
		else $error("write began without start");
	a_key_zero: assert property (sfr_req.rd && sfr_req.sel == DEE_SEL_KEY |=> sfr_rdata == 8'h00)
		else $error("key port not zero");
	a_addr_mask: assert property (sfr_req.rd && sfr_req.sel == DEE_SEL_ADRH |=> sfr_rdata[7:2] == 6'h00)
		else $error("address high bits not zero");
	a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data changed");
endmodule // dee_chk
bind dee_ctrl dee_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_dee_chk (.clock(clock), .rst(rst), .sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata), .write_done_irq_flag(write_done_irq_flag), .write_active(write_active));
`default_nettype wire

/* File: dv/tb.sv */
// Directed bench for the data array controller.
// Drives the register port at falling edges with short cycle counts.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import dee_pkg::*;
	localparam int WC = 6;
	logic       clock = 0;
	logic       rst = 1;
	dee_req_t   sfr_req = '0;
	logic [7:0] sfr_rdata;
	logic       write_done_irq_flag;
	logic       write_active;
	int         num_errors = 0;
	int         checks_done = 0;
	int         n;
	dee_ctrl #(.WRITE_CYCLES(WC), .PWRT_CYCLES(2)) u_dee_ctrl (.clock(clock), .rst(rst), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .write_done_irq_flag(write_done_irq_flag), .write_active(write_active));
	initial forever #4 clock = ~clock;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Strobes drop one cycle later so that no edge sees a pulse twice
	task automatic acc(input logic [2:0] s, input logic w, input logic [7:0] d);
		sfr_req = '{sel: s, wr: w, rd: !w, wdata: d};
		@(negedge clock);
		sfr_req.wr = 0;
		sfr_req.rd = 0;
		@(negedge clock);
	endtask
	task automatic wr(input logic [2:0] s, input logic [7:0] d);
		acc(s, 1, d);
	endtask
	task automatic rd(input logic [2:0] s, input logic [7:0] m, input logic [7:0] e, input string nm);
		acc(s, 0, 8'h00);
		chk(nm, e, sfr_rdata & m);
	endtask
	task automatic unlock(input logic [7:0] c);
		wr(DEE_SEL_KEY, DEE_KEY1);
		wr(DEE_SEL_KEY, DEE_KEY2);
		wr(DEE_SEL_CTL, c);
	endtask
	// Full timed write, with a data write tried while busy
	task automatic do_write(input logic [7:0] c, input logic [7:0] d, input int len);
		wr(DEE_SEL_DATA, d);
		wr(DEE_SEL_CTL, c);
		unlock(c | 8'h02);
		chk("busy", 8'h01, {7'h0, write_active});
		wr(DEE_SEL_DATA, ~d);
		n = 3;
		while (write_active === 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		chk("length", 8'(len), 8'(n));
		chk("done flag", 8'h01, {7'h0, write_done_irq_flag});
		rd(DEE_SEL_DATA, 8'hFF, d, "frozen data");
		rd(DEE_SEL_CTL, 8'h1A, 8'h00, "ctl after write");
		wr(DEE_SEL_IRQ, 8'h00);
		chk("flag clear", 8'h00, {7'h0, write_done_irq_flag});
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#40000;
		num_errors++;
		results();
	end
	initial begin
		repeat (3) @(negedge clock);
		rst = 0;
		rd(DEE_SEL_CTL, 8'hFF, 8'h00, "ctl reset");
		wr(DEE_SEL_ADRH, 8'hFF);
		rd(DEE_SEL_ADRH, 8'hFF, 8'h03, "addr high");
		wr(DEE_SEL_ADRL, 8'hFF);
		rd(DEE_SEL_KEY, 8'hFF, 8'h00, "key port");
		$display("test registers done");
		do_write(8'h04, 8'h5A, WC);
		do_write(8'h84, 8'h22, WC);
		do_write(8'h44, 8'h33, WC);
		wr(DEE_SEL_CTL, 8'h01);
		rd(DEE_SEL_DATA, 8'hFF, 8'h5A, "read back");
		do_write(8'h14, 8'h66, WC / 2);
		wr(DEE_SEL_CTL, 8'h01);
		rd(DEE_SEL_DATA, 8'hFF, DEE_ERASED, "row erase");
		wr(DEE_SEL_DATA, 8'h33);
		wr(DEE_SEL_CTL, 8'h81);
		rd(DEE_SEL_DATA, 8'hFF, 8'h33, "refused read");
		$display("test writes done");
		wr(DEE_SEL_CTL, 8'h84);
		wr(DEE_SEL_CTL, 8'h86);
		rd(DEE_SEL_CTL, 8'hCA, 8'h88, "no keys");
		wr(DEE_SEL_CTL, 8'h00);
		unlock(8'h06);
		chk("same write permit", 8'h00, {7'h0, write_active});
		wr(DEE_SEL_CTL, 8'h04);
		wr(DEE_SEL_KEY, DEE_KEY1);
		rd(DEE_SEL_ADRL, 8'hFF, 8'hFF, "addr low");
		wr(DEE_SEL_KEY, DEE_KEY2);
		wr(DEE_SEL_CTL, 8'h06);
		chk("broken sequence", 8'h00, {7'h0, write_active});
		unlock(8'h06);
		// One reset edge: a second edge with the write already stopped would clear the abort flag
		rst = 1;
		@(negedge clock);
		rst = 0;
		rd(DEE_SEL_CTL, 8'h08, 8'h08, "reset abort");
		$display("test refusals done");
		results();
	end
endmodule // tb
`default_nettype wire

/* File: logic/dee_ctrl.sv */
// Data array access controller: register file, unlock recognizer, timed writes.
// Assumes the core issues at most one register access per cycle on sfr_req.
`timescale 1ns/10ps
`default_nettype none
module dee_ctrl #(
	parameter int WRITE_CYCLES = dee_pkg::DEE_WRITE_CYCLES_DEF,
	parameter int PWRT_CYCLES  = dee_pkg::DEE_PWRT_CYCLES_DEF
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire dee_pkg::dee_req_t sfr_req,
	output var  logic [7:0]       sfr_rdata,
	output var  logic             write_done_irq_flag,
	output var  logic             write_active
);
	import dee_pkg::*;

	// Storage and state
	logic [7:0]   mem [0:DEE_DEPTH-1];
	logic [7:0]   nvm_addr_low;
	logic [1:0]   nvm_addr_high;
	logic [7:0]   nvm_data_byte;
	logic         region_select;
	logic         config_space_select;
	logic         row_erase;
	logic         write_abort_flag;
	logic         write_permit;
	logic         rd_pend;
	logic [15:0]  wcnt;
	logic [15:0]  pcnt;
	dee_unlock_t  ul;
	dee_unlock_t  next_ul;
	dee_wstate_t  ws;
	dee_wstate_t  next_ws;

	function automatic logic hit(input dee_req_t r, input logic [2:0] code);
		hit = r.wr && (r.sel == code);
	endfunction

	// Phase lengths; program gets the odd cycle
	localparam logic [15:0] ERASE_LEN = 16'(WRITE_CYCLES / 2);
	localparam logic [15:0] PROG_LEN  = 16'(WRITE_CYCLES - WRITE_CYCLES / 2);

	// Access decode
	wire            busy      = (ws != DEE_WS_IDLE);
	wire [7:0]      wd        = sfr_req.wdata;
	wire            any_acc   = sfr_req.wr | sfr_req.rd;
	wire            ctl_wr    = hit(sfr_req, DEE_SEL_CTL);
	wire            key_wr    = hit(sfr_req, DEE_SEL_KEY);
	wire            data_wr   = hit(sfr_req, DEE_SEL_DATA) & ~busy;
	wire            adrl_wr   = hit(sfr_req, DEE_SEL_ADRL) & ~busy;
	wire            adrh_wr   = hit(sfr_req, DEE_SEL_ADRH) & ~busy;
	wire            irq_wr    = hit(sfr_req, DEE_SEL_IRQ);
	wire            ctl_upd   = ctl_wr & ~busy;
	wire [DEE_AW-1:0] addr    = {nvm_addr_high, nvm_addr_low};
	wire            data_reg  = ~config_space_select & ~region_select;
	wire            pwrt_busy = (pcnt != 16'h0000);

	// Read start needs both selects clear in the value being written
	wire rd_req = ctl_upd & wd[DEE_B_RD] & ~wd[DEE_B_REGION] & ~wd[DEE_B_CFG];
	// Permit is checked as stored before this write, so one write cannot arm both
	wire wr_try = ctl_upd & wd[DEE_B_WR];
	wire wr_ok  = wr_try & write_permit & (ul == DEE_UL_KEY2) & ~pwrt_busy;
	wire wr_bad = wr_try & ~wr_ok;
	wire phase_end = busy & (wcnt == 16'h0000);
	wire erase_end = phase_end & (ws == DEE_WS_ERASE);
	wire prog_end  = phase_end & (ws == DEE_WS_PROG);
	wire done      = prog_end | (erase_end & row_erase);

	// Unlock recognizer: any access other than the expected one drops it
	always_comb begin
		next_ul = DEE_UL_IDLE;
		if (key_wr && wd == DEE_KEY1) begin
			next_ul = DEE_UL_KEY1;
		end else if (key_wr && wd == DEE_KEY2 && ul == DEE_UL_KEY1) begin
			next_ul = DEE_UL_KEY2;
		end
		if (!any_acc) begin
			next_ul = ul;
		end
	end

	// Write sequencer: erase then program, each phase self-timed
	always_comb begin
		next_ws = ws;
		case (ws)
			DEE_WS_IDLE: begin
				if (wr_ok) begin
					next_ws = DEE_WS_ERASE;
				end
			end
			DEE_WS_ERASE: begin
				if (erase_end) begin
					next_ws = row_erase ? DEE_WS_IDLE : DEE_WS_PROG;
				end
			end
			DEE_WS_PROG: begin
				if (prog_end) begin
					next_ws = DEE_WS_IDLE;
				end
			end
			default: next_ws = DEE_WS_IDLE;
		endcase
	end

	// Read mux; key port and unused bits read as zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = DEE_RST8;
		case (sfr_req.sel)
			DEE_SEL_CTL: begin
				rd_mux = {region_select, config_space_select, 1'b0, row_erase,
					write_abort_flag, write_permit, write_active, rd_pend};
			end
			DEE_SEL_KEY:  rd_mux = DEE_RST8;
			DEE_SEL_DATA: rd_mux = nvm_data_byte;
			DEE_SEL_ADRL: rd_mux = nvm_addr_low;
			DEE_SEL_ADRH: rd_mux = {6'h00, nvm_addr_high};
			DEE_SEL_IRQ:  rd_mux = {3'h0, write_done_irq_flag, 4'h0};
			default:      rd_mux = DEE_RST8;
		endcase
	end

	// State registers
	always_ff @(posedge clock) begin
		if (rst) begin
			ul <= DEE_UL_IDLE;
			ws <= DEE_WS_IDLE;
			rd_pend <= 1'b0;
		end else begin
			ul <= next_ul;
			ws <= next_ws;
			rd_pend <= rd_req;
		end
	end

	// Phase timer, loaded on entry to each phase
	always_ff @(posedge clock) begin
		if (rst) begin
			wcnt <= 16'h0000;
		end else if (wr_ok) begin
			wcnt <= ERASE_LEN - 16'h0001;
		end else if (erase_end) begin
			wcnt <= PROG_LEN - 16'h0001;
		end else if (busy) begin
			wcnt <= wcnt - 16'h0001;
		end
	end

	// Power-up timer; long, so shortened through the parameter in simulation
	always_ff @(posedge clock) begin
		if (rst) begin
			pcnt <= 16'(PWRT_CYCLES);
		end else if (pwrt_busy) begin
			pcnt <= pcnt - 16'h0001;
		end
	end

	// Array: erase to blank, then program; configuration and program memory lie outside
	always_ff @(posedge clock) begin
		if (erase_end && data_reg) begin
			mem[addr] <= DEE_ERASED;
		end else if (prog_end && data_reg) begin
			mem[addr] <= nvm_data_byte;
		end
	end

	// Address and data registers
	always_ff @(posedge clock) begin
		if (rst) begin
			nvm_addr_low <= DEE_RST8;
			nvm_addr_high <= 2'h0;
			nvm_data_byte <= DEE_RST8;
		end else begin
			if (adrl_wr) begin
				nvm_addr_low <= wd;
			end
			if (adrh_wr) begin
				nvm_addr_high <= wd[1:0];
			end
			if (rd_pend) begin
				nvm_data_byte <= mem[addr];
			end else if (data_wr) begin
				nvm_data_byte <= wd;
			end
		end
	end

	// Control fields; selects change only on software writes and are cleared by reset, even mid-write
	always_ff @(posedge clock) begin
		if (rst) begin
			region_select <= 1'b0;
			config_space_select <= 1'b0;
			write_permit <= 1'b0;
			row_erase <= 1'b0;
		end else begin
			if (ctl_upd) begin
				region_select <= wd[DEE_B_REGION];
				config_space_select <= wd[DEE_B_CFG];
				write_permit <= wd[DEE_B_PERMIT];
			end
			if (done) begin
				row_erase <= 1'b0;
			end else if (ctl_upd) begin
				row_erase <= wd[DEE_B_ROWER];
			end
		end
	end

	// Abort flag: a reset edge mid-write sets it, a reset edge while idle clears it; hardware set beats software
	always_ff @(posedge clock) begin
		if (rst) begin
			if (busy) begin
				write_abort_flag <= 1'b1;
			end else begin
				write_abort_flag <= 1'b0;
			end
		end else if (wr_ok || wr_bad) begin
			write_abort_flag <= 1'b1;
		end else if (done) begin
			write_abort_flag <= 1'b0;
		end else if (ctl_upd) begin
			write_abort_flag <= wd[DEE_B_ABORT];
		end
	end

	// Write start bit and completion flag; software writes of zero do not clear the start bit
	always_ff @(posedge clock) begin
		if (rst) begin
			write_active <= 1'b0;
			write_done_irq_flag <= 1'b0;
		end else begin
			if (wr_ok) begin
				write_active <= 1'b1;
			end else if (done) begin
				write_active <= 1'b0;
			end
			if (done) begin
				write_done_irq_flag <= 1'b1;
			end else if (irq_wr && !wd[DEE_B_IRQ]) begin
				write_done_irq_flag <= 1'b0;
			end
		end
	end

	// Registered read data
	always_ff @(posedge clock) begin
		if (rst) begin
			sfr_rdata <= DEE_RST8;
		end else if (sfr_req.rd) begin
			sfr_rdata <= rd_mux;
		end
	end
endmodule // dee_ctrl
`default_nettype wire

/* File: logic/dee_pkg.sv */
// Constants, field layout and types of the data array access controller.
// Assumes a core-side register port on the same clock as the controller.
// Operation
// - Array address is high register bits 1:0 over full low register, 000h to 3FFh.
// - One 8-bit data register sources writes and receives reads.
// - Each byte write erases the location, then programs the new byte.
// - An internal timer paces each write to completion, no software pacing.
// - Control bit 7 clear selects the data array, set selects program memory.
// - Control bit 6 set selects configuration space, else bit 7 decides.
// - Writes run only while control bit 2 is set; it clears at power-up.
// - Control bit 3 flags a write cut by reset or started improperly; here also set while any write runs, and a second reset edge clears it.
// - Abort leaves the region and configuration select bits untouched; here reset clears both, even mid-write.
// - Write start bit 1 is set-only by software, cleared by hardware at end.
// - Flag register bit 4 sets when a write ends; only software clears it.
// - Read start bit 0 is set-only; the read takes one cycle and self-clears.
// - Read start is refused while region or configuration select is 1.
// - Control bit 4 arms a row erase for the next write, cleared at its end.
// - Unlock key port stores nothing and reads as zero.
// - Read data is in the data register by the cycle after read start.
// - Data register holds read value until another read or a software write.
// - Write starts only after keys 55h then 0AAh, then write start, per byte.
// - Write start needs write permit set by an earlier register write.
// - During a write, control, address and data registers are frozen.
// - Array writes are blocked during the power-up timer interval.
package dee_pkg;
	// Register select codes on the core port
	localparam logic [2:0] DEE_SEL_CTL   = 3'h0;
	localparam logic [2:0] DEE_SEL_KEY   = 3'h1;
	localparam logic [2:0] DEE_SEL_DATA  = 3'h2;
	localparam logic [2:0] DEE_SEL_ADRL  = 3'h3;
	localparam logic [2:0] DEE_SEL_ADRH  = 3'h4;
	localparam logic [2:0] DEE_SEL_IRQ   = 3'h5;
	// Control register bit positions, then the flag register bit
	localparam int DEE_B_REGION = 7;
	localparam int DEE_B_CFG    = 6;
	localparam int DEE_B_ROWER  = 4;
	localparam int DEE_B_ABORT  = 3;
	localparam int DEE_B_PERMIT = 2;
	localparam int DEE_B_WR     = 1;
	localparam int DEE_B_RD     = 0;
	localparam int DEE_B_IRQ    = 4;
	// Array geometry and values
	localparam int         DEE_AW     = 10;
	localparam int         DEE_DEPTH  = 1024;
	localparam logic [7:0] DEE_KEY1   = 8'h55;
	localparam logic [7:0] DEE_KEY2   = 8'hAA;
	localparam logic [7:0] DEE_ERASED = 8'hFF;
	localparam logic [7:0] DEE_RST8   = 8'h00;
	// Cycle counts
	localparam int DEE_WRITE_CYCLES_DEF = 512;
	localparam int DEE_PWRT_CYCLES_DEF  = 8192;

	typedef struct packed {
		logic [2:0] sel;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} dee_req_t;

	typedef enum logic [1:0] {DEE_UL_IDLE, DEE_UL_KEY1, DEE_UL_KEY2} dee_unlock_t;
	typedef enum logic [1:0] {DEE_WS_IDLE, DEE_WS_ERASE, DEE_WS_PROG} dee_wstate_t;
endpackage
